//--- shared/rcm_pkg.sv
// Contract
// - reset command: stop test, defaults, go remote
// - enter-remote command: stop test, go remote
// - enter-remote keeps the current configuration
// - remote mode blocks front-panel setup keys
// - remote mode keeps field and value keys
// - remote mode keeps result scrolling keys
// - store saves configuration to slot 1..10
// - store name given, else mode title
// - status query answers remote-mode status
// - enter-remote refused while menu shown; refused only if not already remote
// - last-saved query returns last stored slot
// - name query returns slot name
// - clear command erases a slot
// - recall leaves remote, loads slot configuration
package rcm_pkg;

  // ***********************************************
  // sizes, ranges and reset values
  // ***********************************************
  localparam int SLOT_W = 32'h4;
  localparam logic [SLOT_W-1:0] SLOT_MIN = 4'h1;
  localparam logic [SLOT_W-1:0] SLOT_MAX = 4'hA;
  localparam int SLOTS_DEF = 32'hA;
  localparam int NAME_W_DEF = 32'h40;
  localparam int CFG_W_DEF = 32'h20;
  localparam logic [SLOT_W-1:0] LAST_RST = 4'h0;
  localparam logic REMOTE_RST = 1'h0;

  // ***********************************************
  // enumerations
  // ***********************************************
  typedef enum logic [3:0] {
    CMD_RESET, CMD_REMOTE, CMD_PRESET, CMD_STATUS_Q, CMD_STORE,
    CMD_RECALL, CMD_CLEAR, CMD_NAME_Q, CMD_LAST_Q
  } rcm_cmd_type;

  typedef enum logic [2:0] {
    ERR_NONE, ERR_RANGE, ERR_MENU, ERR_CONTEXT, ERR_EMPTY
  } rcm_err_type;

  typedef enum logic [1:0] {
    KEY_FIELD, KEY_VALUE, KEY_RESULT, KEY_SETUP
  } rcm_key_type;

endpackage : rcm_pkg

//--- shared/rcm_slot_if.sv
`timescale 1ns/1ps
// ***********************************************
// controller to slot store link
// ***********************************************
interface rcm_slot_if #(
  parameter int CFG_W = 32,
  parameter int NAME_W = 64
);
  logic wr_en;
  logic clr_en;
  logic [3:0] idx;
  logic [CFG_W-1:0] wr_cfg;
  logic [NAME_W-1:0] wr_name;
  logic [CFG_W-1:0] rd_cfg;
  logic [NAME_W-1:0] rd_name;
  logic rd_used;

  modport ctrl (output wr_en, clr_en, idx, wr_cfg, wr_name,
                input rd_cfg, rd_name, rd_used);
  modport store (input wr_en, clr_en, idx, wr_cfg, wr_name,
                 output rd_cfg, rd_name, rd_used);
endinterface : rcm_slot_if

//--- logic/rcm_slot_store.sv
`timescale 1ns/1ps
// ***********************************************
// saved configuration slots
// ***********************************************
module rcm_slot_store #(
  parameter int SLOTS = rcm_pkg::SLOTS_DEF
)(
  input wire logic clk,
  input wire logic resetn,
  rcm_slot_if.store sif
);
  import rcm_pkg::*;

  generate
    if (SLOTS < int'(SLOT_MAX) || SLOTS > 15)
    begin : g_bad_slots
      $error("slot count cannot serve the slot range");
    end
  endgenerate

  logic [$bits(sif.wr_cfg)-1:0] cfg_mem [SLOTS];
  logic [$bits(sif.wr_name)-1:0] name_mem [SLOTS];
  logic [SLOTS-1:0] used_q;
  logic [$bits(sif.rd_cfg)-1:0] rd_cfg_q;
  logic [$bits(sif.rd_name)-1:0] rd_name_q;
  logic rd_used_q;
  logic idx_ok;

  // index guard, out of range reads as empty
  assign idx_ok = int'(sif.idx) < SLOTS;

  // data arrays, no reset needed
  always_ff @(posedge clk)
  begin
    if (sif.wr_en && idx_ok)
    begin
      cfg_mem[sif.idx] <= sif.wr_cfg;
      name_mem[sif.idx] <= sif.wr_name;
    end
  end

  // occupancy bit per slot
  genvar g;
  generate
    for (g = 0; g < SLOTS; g++)
    begin : g_used
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
          used_q[g] <= 1'h0;
        else if (sif.wr_en && int'(sif.idx) == g)
          used_q[g] <= 1'h1;
        else if (sif.clr_en && int'(sif.idx) == g)
          used_q[g] <= 1'h0;
      end
    end
  endgenerate

  // registered read port
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_cfg_q <= '0;
      rd_name_q <= '0;
      rd_used_q <= 1'h0;
    end
    else if (idx_ok)
    begin
      rd_cfg_q <= cfg_mem[sif.idx];
      rd_name_q <= name_mem[sif.idx];
      rd_used_q <= used_q[sif.idx];
    end
    else
      rd_used_q <= 1'h0;
  end

  assign sif.rd_cfg = rd_cfg_q;
  assign sif.rd_name = rd_name_q;
  assign sif.rd_used = rd_used_q;

  a_clear_empties: assert property (@(posedge clk) disable iff (!resetn)
    sif.clr_en && !sif.wr_en && idx_ok |=> !used_q[$past(sif.idx)])
    else $error("cleared slot still marked used");

endmodule : rcm_slot_store

//--- logic/rcm_panel_gate.sv
`timescale 1ns/1ps
// ***********************************************
// front-panel key gate
// ***********************************************
module rcm_panel_gate (
  input wire logic clk,
  input wire logic resetn,
  input wire logic remote,
  input wire logic key_valid,
  input wire rcm_pkg::rcm_key_type key_kind,
  output logic key_pass,
  output logic key_blocked
);
  import rcm_pkg::*;

  logic pass_q;
  logic pass_d;
  logic block_q;
  logic block_d;
  logic setup_key;

  // setup keys are refused in remote, display keys pass
  assign setup_key = key_kind == KEY_SETUP;
  assign block_d = key_valid && remote && setup_key;
  assign pass_d = key_valid && !block_d;

  // one-cycle key outcome pulses
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pass_q <= 1'h0;
      block_q <= 1'h0;
    end
    else
    begin
      pass_q <= pass_d;
      block_q <= block_d;
    end
  end

  assign key_pass = pass_q;
  assign key_blocked = block_q;

  a_setup_blocked: assert property (@(posedge clk) disable iff (!resetn)
    key_valid && remote && key_kind == KEY_SETUP |=> key_blocked && !key_pass)
    else $error("setup key passed in remote mode");

  a_display_keys: assert property (@(posedge clk) disable iff (!resetn)
    key_valid && key_kind != KEY_SETUP |=> key_pass && !key_blocked)
    else $error("display key refused");

endmodule : rcm_panel_gate

//--- logic/rcm_remote_ctrl.sv
`timescale 1ns/1ps
// ***********************************************
// remote mode and store/recall interpreter
// ***********************************************
module rcm_remote_ctrl #(
  parameter int NAME_W = rcm_pkg::NAME_W_DEF,
  parameter int CFG_W = rcm_pkg::CFG_W_DEF
)(
  input wire logic clk,
  input wire logic resetn,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire rcm_pkg::rcm_cmd_type cmd_code,
  input wire logic [rcm_pkg::SLOT_W-1:0] cmd_slot,
  input wire logic cmd_name_given,
  input wire logic [NAME_W-1:0] cmd_name,
  input wire logic menu_shown,
  input wire logic test_running,
  input wire logic [CFG_W-1:0] cur_cfg,
  input wire logic [NAME_W-1:0] mode_title,
  output logic rsp_valid,
  output logic [NAME_W-1:0] rsp_data,
  output logic remote_mode,
  output rcm_pkg::rcm_err_type err_code,
  output logic stop_test,
  output logic cfg_defaults,
  output logic cfg_load,
  output logic [CFG_W-1:0] cfg_data,
  input wire logic key_valid,
  input wire rcm_pkg::rcm_key_type key_kind,
  output logic key_pass,
  output logic key_blocked
);
  import rcm_pkg::*;

  generate
    if (NAME_W < 8 || CFG_W < 1)
    begin : g_bad_widths
      $error("name must hold status and slot, config nonempty");
    end
  endgenerate

  // ***********************************************
  // state and storage
  // ***********************************************
  typedef enum logic [1:0] {S_IDLE, S_ACCESS, S_FINISH} rcm_state_type;

  rcm_state_type state_q;
  rcm_state_type state_d;
  rcm_cmd_type op_q;
  logic [SLOT_W-1:0] slot_q;
  logic [NAME_W-1:0] name_q;
  logic [CFG_W-1:0] cfg_cap_q;
  logic running_q;
  logic menu_q;
  logic remote_q;
  logic remote_d;
  rcm_err_type err_q;
  rcm_err_type err_d;
  logic [SLOT_W-1:0] last_q;
  logic [SLOT_W-1:0] last_d;
  logic rsp_valid_q;
  logic rsp_valid_d;
  logic [NAME_W-1:0] rsp_data_q;
  logic [NAME_W-1:0] rsp_data_d;
  logic stop_q;
  logic stop_d;
  logic dflt_q;
  logic dflt_d;
  logic load_q;
  logic load_d;
  logic [CFG_W-1:0] cfg_data_q;
  logic [CFG_W-1:0] cfg_data_d;

  // ***********************************************
  // command decode
  // ***********************************************
  logic take;
  logic slot_ok;
  logic uses_slot;
  logic remote_only;
  logic ctx_ok;
  logic range_bad;
  logic menu_bad;
  logic op_ok;
  logic [SLOT_W-1:0] mem_idx;

  // one command at a time, taken only when idle
  assign take = cmd_valid && cmd_ready;
  assign slot_ok = slot_q >= SLOT_MIN && slot_q <= SLOT_MAX;
  assign uses_slot = op_q == CMD_STORE || op_q == CMD_RECALL ||
                     op_q == CMD_CLEAR || op_q == CMD_NAME_Q;
  assign remote_only = op_q == CMD_RECALL || op_q == CMD_CLEAR ||
                       op_q == CMD_NAME_Q || op_q == CMD_LAST_Q;
  // store is a local command, slot maintenance a remote one
  assign ctx_ok = op_q == CMD_STORE ? !remote_q :
                  remote_only ? remote_q : 1'h1;
  assign range_bad = uses_slot && !slot_ok;
  assign menu_bad = op_q == CMD_REMOTE && menu_q && !remote_q;
  assign op_ok = ctx_ok && !range_bad && !menu_bad;
  assign mem_idx = slot_q - SLOT_MIN;

  // ***********************************************
  // slot store
  // ***********************************************
  rcm_slot_if #(.CFG_W(CFG_W), .NAME_W(NAME_W)) sif ();

  // writes and erases only for accepted commands
  assign sif.wr_en = state_q == S_ACCESS && op_q == CMD_STORE && op_ok;
  assign sif.clr_en = state_q == S_ACCESS && op_q == CMD_CLEAR && op_ok;
  assign sif.idx = mem_idx;
  assign sif.wr_cfg = cfg_cap_q;
  assign sif.wr_name = name_q;

  rcm_slot_store #(.SLOTS(SLOTS_DEF)) u_store (
    .clk(clk),
    .resetn(resetn),
    .sif(sif)
  );

  // ***********************************************
  // command capture
  // ***********************************************
  // latch the command and its context on take
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      op_q <= CMD_STATUS_Q;
      slot_q <= '0;
      name_q <= '0;
      cfg_cap_q <= '0;
      running_q <= 1'h0;
      menu_q <= 1'h0;
    end
    else if (take)
    begin
      op_q <= cmd_code;
      slot_q <= cmd_slot;
      name_q <= cmd_name_given ? cmd_name : mode_title;
      cfg_cap_q <= cur_cfg;
      running_q <= test_running;
      menu_q <= menu_shown;
    end
  end

  // ***********************************************
  // execution
  // ***********************************************
  // next state and command effects, applied in finish
  always_comb
  begin
    state_d = state_q;
    remote_d = remote_q;
    err_d = err_q;
    last_d = last_q;
    rsp_valid_d = 1'h0;
    rsp_data_d = rsp_data_q;
    stop_d = 1'h0;
    dflt_d = 1'h0;
    load_d = 1'h0;
    cfg_data_d = cfg_data_q;
    case (state_q)
      S_IDLE:
        if (take)
          state_d = S_ACCESS;
      S_ACCESS:
        state_d = S_FINISH;
      S_FINISH:
      begin
        state_d = S_IDLE;
        rsp_valid_d = 1'h1;
        rsp_data_d = '0;
        if (!ctx_ok)
          err_d = ERR_CONTEXT;
        else if (range_bad)
          err_d = ERR_RANGE;
        else if (menu_bad)
          err_d = ERR_MENU;
        else
        begin
          case (op_q)
            CMD_RESET:
            begin
              stop_d = running_q;
              dflt_d = 1'h1;
              remote_d = 1'h1;
            end
            CMD_REMOTE:
            begin
              stop_d = running_q;
              remote_d = 1'h1;
            end
            CMD_PRESET: remote_d = 1'h0;
            CMD_STATUS_Q:
            begin
              rsp_data_d = NAME_W'({remote_q, err_q});
              err_d = ERR_NONE;
            end
            CMD_STORE: last_d = slot_q;
            CMD_RECALL:
            begin
              if (sif.rd_used)
              begin
                remote_d = 1'h0;
                load_d = 1'h1;
                cfg_data_d = sif.rd_cfg;
              end
              else
                err_d = ERR_EMPTY;
            end
            CMD_NAME_Q:
              if (sif.rd_used)
                rsp_data_d = sif.rd_name;
            CMD_LAST_Q: rsp_data_d = NAME_W'(last_q);
            default: rsp_data_d = '0;
          endcase
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  // control state
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= S_IDLE;
      remote_q <= REMOTE_RST;
      err_q <= ERR_NONE;
      last_q <= LAST_RST;
    end
    else
    begin
      state_q <= state_d;
      remote_q <= remote_d;
      err_q <= err_d;
      last_q <= last_d;
    end
  end

  // answer and action outputs
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rsp_valid_q <= 1'h0;
      rsp_data_q <= '0;
      stop_q <= 1'h0;
      dflt_q <= 1'h0;
      load_q <= 1'h0;
      cfg_data_q <= '0;
    end
    else
    begin
      rsp_valid_q <= rsp_valid_d;
      rsp_data_q <= rsp_data_d;
      stop_q <= stop_d;
      dflt_q <= dflt_d;
      load_q <= load_d;
      cfg_data_q <= cfg_data_d;
    end
  end

  // ***********************************************
  // front panel
  // ***********************************************
  rcm_panel_gate u_gate (
    .clk(clk),
    .resetn(resetn),
    .remote(remote_q),
    .key_valid(key_valid),
    .key_kind(key_kind),
    .key_pass(key_pass),
    .key_blocked(key_blocked)
  );

  // port drives
  assign cmd_ready = state_q == S_IDLE;
  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;
  assign remote_mode = remote_q;
  assign err_code = err_q;
  assign stop_test = stop_q;
  assign cfg_defaults = dflt_q;
  assign cfg_load = load_q;
  assign cfg_data = cfg_data_q;

  // ***********************************************
  // checks
  // ***********************************************
  a_reset_cmd: assert property (@(posedge clk) disable iff (!resetn)
    take && cmd_code == CMD_RESET |-> ##3 remote_mode && cfg_defaults &&
      rsp_valid && stop_test == $past(test_running, 3))
    else $error("reset command effects wrong");

  a_remote_entry: assert property (@(posedge clk) disable iff (!resetn)
    take && cmd_code == CMD_REMOTE && !menu_shown |-> ##3 remote_mode &&
      stop_test == $past(test_running, 3))
    else $error("enter-remote did not take effect");

  a_remote_keeps_cfg: assert property (@(posedge clk) disable iff (!resetn)
    take && cmd_code == CMD_REMOTE |-> ##3 !cfg_defaults && !cfg_load)
    else $error("enter-remote touched the configuration");

  a_menu_refuse: assert property (@(posedge clk) disable iff (!resetn)
    take && cmd_code == CMD_REMOTE && menu_shown && !remote_mode
      |-> ##3 !remote_mode && err_code == ERR_MENU)
    else $error("enter-remote accepted over a menu");

  a_preset_local: assert property (@(posedge clk) disable iff (!resetn)
    take && cmd_code == CMD_PRESET |-> ##3 !remote_mode && rsp_valid)
    else $error("preset left remote mode on");

  a_store_last: assert property (@(posedge clk) disable iff (!resetn)
    take && cmd_code == CMD_STORE && !remote_mode &&
      cmd_slot >= SLOT_MIN && cmd_slot <= SLOT_MAX
      |-> ##1 sif.wr_en ##2 last_q == $past(cmd_slot, 3))
    else $error("store did not record its slot");

  a_range_refuse: assert property (@(posedge clk) disable iff (!resetn)
    take && (cmd_code == CMD_STORE || cmd_code == CMD_CLEAR) &&
      (cmd_slot < SLOT_MIN || cmd_slot > SLOT_MAX)
      |-> ##1 !sif.wr_en && !sif.clr_en ##2
        (err_code == ERR_RANGE || err_code == ERR_CONTEXT))
    else $error("bad slot number was not refused");

  a_recall_local: assert property (@(posedge clk) disable iff (!resetn)
    cfg_load |-> !remote_mode && $past(op_q, 1) == CMD_RECALL)
    else $error("recall load without leaving remote");

endmodule : rcm_remote_ctrl

//--- tb/rcm_host_model.sv
`timescale 1ns/1ps
// ************************************
// host controller model
// ************************************
module rcm_host_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic req,
  input wire rcm_pkg::rcm_cmd_type req_code,
  input wire logic [3:0] req_slot,
  input wire logic req_name_given,
  input wire logic [63:0] req_name,
  output logic cmd_valid,
  input wire logic cmd_ready,
  output rcm_pkg::rcm_cmd_type cmd_code,
  output logic [3:0] cmd_slot,
  output logic cmd_name_given,
  output logic [63:0] cmd_name
);
  import rcm_pkg::*;
  // offer held until taken, then slot, name flag and name scrambled (code kept) so stale values never match
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cmd_valid <= 1'h0;
      cmd_code <= CMD_STATUS_Q;
      cmd_slot <= 4'h0;
      cmd_name_given <= 1'h0;
      cmd_name <= 64'h0;
    end
    else if (req)
    begin
      // decoded command: colon prefix and full keyword already applied
      cmd_valid <= 1'h1;
      cmd_code <= req_code;
      cmd_slot <= req_slot;
      cmd_name_given <= req_name_given;
      cmd_name <= req_name;
    end
    else if (cmd_valid && cmd_ready)
    begin
      cmd_valid <= 1'h0;
      cmd_slot <= ~cmd_slot;
      cmd_name_given <= ~cmd_name_given;
      cmd_name <= ~cmd_name;
    end
  end
endmodule : rcm_host_model

//--- tb/testbench.sv
`timescale 1ns/1ps
// ************************************
// self-checking bench
// ************************************
module testbench;
  import rcm_pkg::*;
  logic clk, resetn, req, ng, menu, trun, rem_m;
  logic cmd_valid, cmd_ready, cmd_ng, rsp_valid, remote_mode;
  logic stop_test, cfg_defaults, cfg_load, key_valid, key_pass, key_blocked;
  logic kv_q = 1'h0;
  logic rm_q = 1'h0;
  rcm_key_type key_kind, kk_q = KEY_FIELD;
  rcm_cmd_type rc, cmd_code;
  rcm_err_type err_code, err_m;
  logic [3:0] rs, cmd_slot, last_m;
  logic [15:0] used_m;
  logic [63:0] rn, title, rsp_data, cmd_name, name_m [16];
  logic [31:0] cur_cfg, cfg_data, cfg_m [16];
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;

  rcm_host_model host (.clk(clk), .resetn(resetn), .req(req), .req_code(rc),
    .req_slot(rs), .req_name_given(ng), .req_name(rn), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_code(cmd_code), .cmd_slot(cmd_slot),
    .cmd_name_given(cmd_ng), .cmd_name(cmd_name));

  rcm_remote_ctrl uut (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_code(cmd_code), .cmd_slot(cmd_slot),
    .cmd_name_given(cmd_ng), .cmd_name(cmd_name), .menu_shown(menu),
    .test_running(trun), .cur_cfg(cur_cfg), .mode_title(title),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .remote_mode(remote_mode),
    .err_code(err_code), .stop_test(stop_test), .cfg_defaults(cfg_defaults),
    .cfg_load(cfg_load), .cfg_data(cfg_data), .key_valid(key_valid),
    .key_kind(key_kind), .key_pass(key_pass), .key_blocked(key_blocked));

  // ************************************
  // clock, timeout, reporting
  // ************************************
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task close_out;
    if (fail_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  task check(string what, logic [63:0] seen, logic [63:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // cycle ceiling against hangs
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc > 6000)
    begin
      fail_count++;
      close_out;
    end
  end

  // ************************************
  // front-panel keys
  // ************************************
  always @(posedge clk)
  begin
    kv_q <= key_valid;
    kk_q <= key_kind;
    rm_q <= remote_mode;
  end

  // key answer one cycle after the key, setup keys refused in remote
  always @(negedge clk)
  begin
    if (resetn && cyc > 12)
    begin
      check("key_pass", key_pass, kv_q && !(rm_q && kk_q == KEY_SETUP));
      check("key_blocked", key_blocked, kv_q && rm_q && kk_q == KEY_SETUP);
    end
  end

  task keys(int n);
    repeat (n)
    begin
      @(posedge clk);
      key_valid <= 1'($urandom);
      key_kind <= rcm_key_type'($urandom_range(3));
    end
    @(posedge clk);
    key_valid <= 1'h0;
    @(posedge clk);
  endtask : keys

  // ************************************
  // command with predicted answer
  // ************************************
  task do_cmd(rcm_cmd_type c, logic [3:0] s, logic g);
    rcm_err_type e;
    logic [63:0] ed, nm, ti;
    logic [31:0] cf, ecf;
    logic estop, edef, eld;
    int n;
    // let pending menu and test-running updates settle before predicting
    @(posedge clk);
    nm = {$urandom, $urandom};
    ti = {$urandom, $urandom};
    cf = $urandom;
    ecf = 32'h0;
    ed = 64'h0;
    estop = 1'h0;
    edef = 1'h0;
    eld = 1'h0;
    e = ERR_NONE;
    if (c == CMD_RECALL && !used_m[s]) e = ERR_EMPTY;
    if (c == CMD_REMOTE && menu && !rem_m) e = ERR_MENU;
    if (c inside {CMD_STORE, CMD_RECALL, CMD_CLEAR, CMD_NAME_Q} && (s < 1 || s > 10))
      e = ERR_RANGE;
    if ((c == CMD_STORE && rem_m) ||
        (c inside {CMD_RECALL, CMD_CLEAR, CMD_NAME_Q, CMD_LAST_Q} && !rem_m))
      e = ERR_CONTEXT;
    if (e != ERR_NONE)
      err_m = e;
    else
      case (c)
        CMD_RESET: {rem_m, edef, estop} = {2'h3, trun};
        CMD_REMOTE: {rem_m, estop} = {1'h1, trun};
        CMD_PRESET: rem_m = 1'h0;
        CMD_STATUS_Q:
        begin
          ed = {60'h0, rem_m, err_m};
          err_m = ERR_NONE;
        end
        CMD_STORE: {used_m[s], cfg_m[s], name_m[s], last_m} = {1'h1, cf, g ? nm : ti, s};
        CMD_RECALL: {eld, ecf, rem_m} = {1'h1, cfg_m[s], 1'h0};
        CMD_CLEAR: used_m[s] = 1'h0;
        CMD_NAME_Q: ed = used_m[s] ? name_m[s] : 64'h0;
        default: ed = {60'h0, last_m};
      endcase
    req <= 1'h1;
    rc <= c;
    rs <= s;
    ng <= g;
    rn <= nm;
    cur_cfg <= cf;
    title <= ti;
    @(posedge clk);
    req <= 1'h0;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end while (!rsp_valid && n < 20);
    check("rsp_valid", rsp_valid, 1'h1);
    check("rsp_data", rsp_data, ed);
    check("err_code", err_code, err_m);
    check("remote_mode", remote_mode, rem_m);
    check("stop_test", stop_test, estop);
    check("cfg_defaults", cfg_defaults, edef);
    check("cfg_load", cfg_load, eld);
    if (eld) check("cfg_data", cfg_data, ecf);
  endtask : do_cmd

  // ************************************
  // main sequence
  // ************************************
  initial
  begin
    {resetn, req, ng, menu, trun, rem_m, key_valid} = 7'h0;
    {rs, last_m, used_m, rn, title, cur_cfg} = '0;
    rc = CMD_STATUS_Q;
    err_m = ERR_NONE;
    key_kind = KEY_FIELD;
    void'($urandom(32'hAFFF));
    repeat (10) @(posedge clk);
    resetn <= 1'h1;
    @(posedge clk);
    #1;
    check("cmd_ready", cmd_ready, 1'h1);
    check("remote_mode", remote_mode, 1'h0);
    check("err_code", err_code, ERR_NONE);
    do_cmd(CMD_STATUS_Q, 4'h0, 1'h0);
    @(posedge clk) menu <= 1'h1;
    do_cmd(CMD_REMOTE, 4'h0, 1'h0);
    do_cmd(CMD_STATUS_Q, 4'h0, 1'h0);
    @(posedge clk) menu <= 1'h0;
    do_cmd(CMD_STORE, 4'h1, 1'h1);
    do_cmd(CMD_STORE, 4'hA, 1'h0);
    do_cmd(CMD_STORE, 4'h0, 1'h1);
    do_cmd(CMD_STORE, 4'hB, 1'h1);
    repeat (6) do_cmd(CMD_STORE, 4'($urandom_range(12)), 1'($urandom));
    do_cmd(CMD_RECALL, 4'h1, 1'h0);
    keys(20);
    @(posedge clk) trun <= 1'h1;
    do_cmd(CMD_REMOTE, 4'h0, 1'h0);
    keys(30);
    do_cmd(CMD_STORE, 4'h2, 1'h0);
    do_cmd(CMD_LAST_Q, 4'h0, 1'h0);
    for (int i = 0; i < 16; i++) do_cmd(CMD_NAME_Q, 4'(i), 1'h0);
    do_cmd(CMD_CLEAR, 4'hA, 1'h0);
    do_cmd(CMD_NAME_Q, 4'hA, 1'h0);
    do_cmd(CMD_RECALL, 4'hA, 1'h0);
    do_cmd(CMD_CLEAR, 4'hC, 1'h0);
    do_cmd(CMD_RECALL, 4'h1, 1'h0);
    do_cmd(CMD_RESET, 4'h0, 1'h0);
    do_cmd(CMD_PRESET, 4'h0, 1'h0);
    repeat (60)
    begin
      @(posedge clk);
      menu <= 1'($urandom);
      trun <= 1'($urandom);
      do_cmd(rcm_cmd_type'($urandom_range(8)), 4'($urandom_range(11)), 1'($urandom));
    end
    close_out;
  end
endmodule : testbench
